// >>> oser_pkg.sv
// Purpose: Shared constants and types for the operation status event block
// Assumes: One 100 MHz clock, power levels in watts with four fraction bits
// Notes: Rated voltage and current are plain defaults, set per model
`default_nettype none

package oser_pkg;

    // Width of the operation event word
    localparam int EV_W = 32'h0000_0010;

    // Bit positions of the operation condition and event word
    localparam int B_PWR_REG = 32'h0000_000F;
    localparam int B_PWR_LIM = 32'h0000_000E;
    localparam int B_AREF_I = 32'h0000_000D;
    localparam int B_AREF_V = 32'h0000_000C;
    localparam int B_CUR_FOLD = 32'h0000_000B;
    localparam int B_EN_FUNC = 32'h0000_000A;
    localparam int B_ILK = 32'h0000_0009;
    localparam int B_UNDERV = 32'h0000_0008;
    localparam int B_PANEL = 32'h0000_0007;
    localparam int B_SEQ = 32'h0000_0006;
    localparam int B_FOLD_EN = 32'h0000_0005;
    localparam int B_AUTOSTART = 32'h0000_0004;
    localparam int B_TRIG_WAIT = 32'h0000_0003;
    localparam int B_FAULT_FREE = 32'h0000_0002;
    localparam int B_LOOP_I = 32'h0000_0001;
    localparam int B_LOOP_V = 32'h0000_0000;

    // Reset values
    localparam logic [15:0] EVT_RESET = 16'h0000;
    localparam logic [23:0] PWR_RESET = 24'h00_0000;

    // Power limit format and rating
    localparam int PWR_FRAC = 32'h0000_0004;
    localparam int RATED_V = 32'h0000_003C;
    localparam int RATED_I = 32'h0000_0055;
    localparam logic [23:0] PWR_MAX_Q = 24'(RATED_V * RATED_I * (1 << PWR_FRAC));
    localparam logic [24:0] PWR_RND = 25'h000_0008;
    localparam logic [16:0] PWR_DIG_MAX = 17'h1_869F;

    // Questionable fault vector width
    localparam int FLT_W = 32'h0000_0010;

    // Active regulation loop
    typedef enum logic [1:0] {
        OSER_LOOP_NONE,
        OSER_LOOP_VOLT,
        OSER_LOOP_CURR
    } oser_loop_t;

    // Internal operating state flags of the supply
    typedef struct packed {
        logic power_regulation_active;
        logic power_limit_enabled;
        logic analog_current_ref_sel;
        logic analog_voltage_ref_sel;
        logic current_foldback_on;
        logic enable_function_on;
        logic undervoltage_protect_flag;
        logic front_panel_control;
        logic sequencer_running;
        logic foldback_enabled;
        logic autostart_enabled;
        logic trigger_waiting;
    } oser_state_t;

endpackage : oser_pkg

`default_nettype wire

// >>> oser_event_reg.sv
// Purpose: Operation condition word, its event latch, and the power limit store
// Assumes: State flags come from logic on i_clk; interlock arrives from a pin
// Notes: Events latch rising edges of enabled conditions; a query clears them
//
// What this block does
// - Stored power limit is clamped to rated voltage times rated current.
// - Power query returns stored level rounded to whole watts, five digits.
// - Host writes to the event latch change nothing.
// - Event bits set on condition rising edge and hold when it falls.
// - Reading the event latch returns its value then clears it.
// - Only conditions enabled by the enable word are latched.
// - Upper byte: power reg, limit on, analog I, analog V, foldback, enable, interlock, undervoltage.
// - Lower byte: local, sequencer, foldback on, autostart, trigger wait, no fault, current, voltage.
// - Constant power flag follows power regulation activity.
// - Power limit flag follows power limiting function switched on.
// - Analog current reference flag follows analog current programming.
// - Analog voltage reference flag follows analog voltage programming.
// - Local flag follows front panel control.
// - Sequencer flag holds while sequencer runs.
// - Foldback enabled flag follows foldback protection enable.
// - Current foldback flag follows foldback on entering current regulation.
// - Autostart flag follows automatic start-up enable.
// - Trigger wait flag holds while armed for a trigger.
// - Enable function flag follows external enable function.
`timescale 1ns/100ps
`default_nettype none

module oser_event_reg
    import oser_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire oser_state_t i_state,
    input wire oser_loop_t i_loop,
    input wire logic i_interlock,
    input wire logic [FLT_W-1:0] i_fault,
    input wire logic [EV_W-1:0] i_oper_enable,
    input wire logic i_evt_rd,
    input wire logic i_evt_wr,
    input wire logic [EV_W-1:0] i_evt_wdata,
    input wire logic i_pwr_wr,
    input wire logic [23:0] i_pwr_level,
    input wire logic i_pwr_rd,
    output logic [EV_W-1:0] o_oper_cond,
    output logic [EV_W-1:0] o_evt_data,
    output logic o_evt_valid,
    output logic [16:0] o_pwr_bin,
    output logic [19:0] o_pwr_bcd,
    output logic o_pwr_valid
);

    // Binary to five BCD digits by shift and add-three
    function automatic logic [19:0] oser_bcd(input logic [16:0] v);
        logic [36:0] s;
        s = {20'h0_0000, v};
        for (int i = 0; i < 17; i++)
        begin
            for (int d = 0; d < 5; d++)
            begin
                if (s[17 + 4 * d +: 4] >= 4'h5)
                begin
                    s[17 + 4 * d +: 4] = s[17 + 4 * d +: 4] + 4'h3;
                end
            end
            s = {s[35:0], 1'b0};
        end
        return s[36:17];
    endfunction : oser_bcd

    logic ilk_s1_q;
    logic ilk_s2_q;
    logic [EV_W-1:0] cond_w;
    logic [EV_W-1:0] armed_w;
    logic [EV_W-1:0] rise_w;
    logic [EV_W-1:0] armed_q;
    logic [EV_W-1:0] evt_d;
    logic [EV_W-1:0] evt_q;
    logic [23:0] pwr_d;
    logic [23:0] pwr_q;
    logic [24:0] rnd_full_w;
    logic [20:0] rnd_whole_w;
    logic [16:0] rnd_w;

    // Interlock pin synchroniser
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            ilk_s1_q <= 1'b0;
            ilk_s2_q <= 1'b0;
        end
        else
        begin
            ilk_s1_q <= i_interlock;
            ilk_s2_q <= ilk_s1_q;
        end
    end

    // Condition word assembly
    assign cond_w[B_PWR_REG] = i_state.power_regulation_active;
    assign cond_w[B_PWR_LIM] = i_state.power_limit_enabled;
    assign cond_w[B_AREF_I] = i_state.analog_current_ref_sel;
    assign cond_w[B_AREF_V] = i_state.analog_voltage_ref_sel;
    assign cond_w[B_CUR_FOLD] = i_state.current_foldback_on;
    assign cond_w[B_EN_FUNC] = i_state.enable_function_on;
    assign cond_w[B_ILK] = ilk_s2_q;
    assign cond_w[B_UNDERV] = i_state.undervoltage_protect_flag;
    assign cond_w[B_PANEL] = i_state.front_panel_control;
    assign cond_w[B_SEQ] = i_state.sequencer_running;
    assign cond_w[B_FOLD_EN] = i_state.foldback_enabled;
    assign cond_w[B_AUTOSTART] = i_state.autostart_enabled;
    assign cond_w[B_TRIG_WAIT] = i_state.trigger_waiting;
    assign cond_w[B_FAULT_FREE] = ~|i_fault;
    assign cond_w[B_LOOP_I] = (i_loop == OSER_LOOP_CURR);
    assign cond_w[B_LOOP_V] = (i_loop == OSER_LOOP_VOLT);

    // Enabled conditions and their rising edges
    assign armed_w = cond_w & i_oper_enable;
    assign rise_w = armed_w & ~armed_q;

    // Next event word; a new edge wins over the read clear, writes ignored
    assign evt_d = (i_evt_rd ? EVT_RESET : evt_q) | rise_w;

    // Event latch and condition readout
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            armed_q <= EVT_RESET;
            evt_q <= EVT_RESET;
            o_oper_cond <= EVT_RESET;
        end
        else
        begin
            armed_q <= armed_w;
            evt_q <= evt_d;
            o_oper_cond <= cond_w;
        end
    end

    // Event query answer
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_evt_data <= EVT_RESET;
            o_evt_valid <= 1'b0;
        end
        else
        begin
            o_evt_valid <= i_evt_rd;
            if (i_evt_rd)
            begin
                o_evt_data <= evt_q;
            end
        end
    end

    // Power limit clamp on write
    assign pwr_d = (i_pwr_level > PWR_MAX_Q) ? PWR_MAX_Q : i_pwr_level;

    // Rounding to nearest watt, saturated to five digits
    assign rnd_full_w = {1'b0, pwr_q} + PWR_RND;
    assign rnd_whole_w = rnd_full_w[24:PWR_FRAC];
    assign rnd_w = (rnd_whole_w > {4'h0, PWR_DIG_MAX}) ? PWR_DIG_MAX : rnd_whole_w[16:0];

    // Power limit store and query answer
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            pwr_q <= PWR_RESET;
            o_pwr_bin <= 17'h0_0000;
            o_pwr_bcd <= 20'h0_0000;
            o_pwr_valid <= 1'b0;
        end
        else
        begin
            o_pwr_valid <= i_pwr_rd;
            if (i_pwr_wr)
            begin
                pwr_q <= pwr_d;
            end
            if (i_pwr_rd)
            begin
                o_pwr_bin <= rnd_w;
                o_pwr_bcd <= oser_bcd(rnd_w);
            end
        end
    end

    // Query steps
    sequence s_evt_query;
        i_evt_rd;
    endsequence

    sequence s_evt_answer(logic [EV_W-1:0] v);
        o_evt_valid && (o_evt_data == v);
    endsequence

    // Checks
    a_write_no_effect: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_evt_wr && !i_evt_rd && (rise_w == EVT_RESET)) |=> (evt_q == $past(evt_q)))
        else $error("event word changed on a write");

    a_rise_sets_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (rise_w != EVT_RESET) |=> ((evt_q & $past(rise_w)) == $past(rise_w)))
        else $error("rising condition not latched");

    a_fall_holds_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_evt_rd |=> (($past(evt_q) & ~evt_q) == EVT_RESET))
        else $error("event bit dropped without a read");

    a_read_returns_val: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_evt_query |=> s_evt_answer($past(evt_q)))
        else $error("event query returned wrong value");

    a_read_clears_all: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (s_evt_query ##0 (rise_w == EVT_RESET)) |=> (evt_q == EVT_RESET))
        else $error("event word not cleared by read");

    a_enable_gates_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        1'b1 |=> (((evt_q & ~$past(evt_q)) & ~$past(i_oper_enable)) == EVT_RESET))
        else $error("disabled condition latched");

    a_pwr_clamped: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_pwr_wr |=> (pwr_q <= PWR_MAX_Q) && (pwr_q <= $past(i_pwr_level)))
        else $error("power limit above rating");

    a_pwr_rounded: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_pwr_rd |=> o_pwr_valid && (o_pwr_bin <= PWR_DIG_MAX) && ((o_pwr_bin == PWR_DIG_MAX)
            || (o_pwr_bin == 17'(($past(pwr_q) + 24'h00_0008) >> PWR_FRAC))))
        else $error("power readback not rounded");

    a_loop_exclusive: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !(o_oper_cond[B_LOOP_I] && o_oper_cond[B_LOOP_V]))
        else $error("both regulation loop flags set");

    a_no_fault_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
        1'b1 |=> (o_oper_cond[B_FAULT_FREE] == ~|$past(i_fault)))
        else $error("no-fault flag wrong");

    a_interlock_path: assert property (@(posedge i_clk) disable iff (!i_nrst)
        ##3 (o_oper_cond[B_ILK] == $past(i_interlock, 3)))
        else $error("interlock flag not following input");

    // Power query steps
    sequence s_pwr_query;
        i_pwr_rd;
    endsequence

    sequence s_pwr_answer;
        o_pwr_valid && (o_pwr_bin <= PWR_DIG_MAX);
    endsequence

    // Power store and readback checks
    a_pwr_exact_store: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_pwr_wr |=> (pwr_q == (($past(i_pwr_level) > PWR_MAX_Q) ? PWR_MAX_Q
            : $past(i_pwr_level))))
        else $error("power limit not stored as clamped");

    a_pwr_holds_value: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_pwr_wr |=> $stable(pwr_q))
        else $error("power limit changed without a write");

    a_pwr_valid_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_pwr_rd |=> !o_pwr_valid)
        else $error("power answer without a query");

    a_pwr_data_holds: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_pwr_rd |=> $stable(o_pwr_bin) && $stable(o_pwr_bcd))
        else $error("power readback changed without a query");

    a_bcd_digit_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_pwr_query |=> s_pwr_answer ##0 ((o_pwr_bcd[3:0] < 4'hA) && (o_pwr_bcd[7:4] < 4'hA)
            && (o_pwr_bcd[11:8] < 4'hA) && (o_pwr_bcd[15:12] < 4'hA)
            && (o_pwr_bcd[19:16] < 4'hA)))
        else $error("power digit out of range");

    a_bcd_matches_bin: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_pwr_query |=> s_pwr_answer ##0 (32'(o_pwr_bin) == (32'h0000_2710 * o_pwr_bcd[19:16]
            + 32'h0000_03E8 * o_pwr_bcd[15:12] + 32'h0000_0064 * o_pwr_bcd[11:8]
            + 32'h0000_000A * o_pwr_bcd[7:4] + 32'(o_pwr_bcd[3:0]))))
        else $error("power digits disagree with binary readback");

    // Event answer and latch checks
    a_evt_valid_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_evt_rd |=> !o_evt_valid)
        else $error("event answer without a query");

    a_evt_data_holds: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_evt_rd |=> $stable(o_evt_data))
        else $error("event answer changed without a query");

    a_read_keeps_rise: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_evt_query |=> (evt_q == $past(rise_w)))
        else $error("event word after read not limited to new edges");

    a_rise_needs_cond: assert property (@(posedge i_clk) disable iff (!i_nrst)
        1'b1 |=> (((evt_q & ~$past(evt_q)) & ~$past(cond_w)) == EVT_RESET))
        else $error("event bit set without its condition");

    // Condition word checks
    a_state_bit_map: assert property (@(posedge i_clk) disable iff (!i_nrst)
        1'b1 |=> ({o_oper_cond[B_PWR_REG:B_EN_FUNC], o_oper_cond[B_UNDERV:B_TRIG_WAIT]}
            == $past(i_state)))
        else $error("state flag in wrong condition bit");

    a_loop_flags_track: assert property (@(posedge i_clk) disable iff (!i_nrst)
        1'b1 |=> (o_oper_cond[B_LOOP_I] == ($past(i_loop) == OSER_LOOP_CURR))
            && (o_oper_cond[B_LOOP_V] == ($past(i_loop) == OSER_LOOP_VOLT)))
        else $error("regulation loop flag wrong");

endmodule : oser_event_reg

`default_nettype wire

// >>> oser_host_model.sv
// Purpose: Host model issuing status queries and power limit commands
// Assumes: Strobes change at the falling edge and last one cycle
// Notes: Released data lines carry the inverse of the last value
`timescale 1ns/100ps
`default_nettype none

module oser_host_model (
    input wire logic i_clk,
    output logic o_evt_rd,
    output logic o_evt_wr,
    output logic [15:0] o_evt_wdata,
    output logic o_pwr_wr,
    output logic [23:0] o_pwr_level,
    output logic o_pwr_rd
);
    // Idle lines at time zero
    initial
    begin
        {o_evt_rd, o_evt_wr, o_pwr_wr, o_pwr_rd} = 4'h0;
        o_evt_wdata = 16'h0000;
        o_pwr_level = 24'h00_0000;
    end

    // One strobe of kind k: event read, event write, power write, power read
    task automatic strobe(input int k, input logic [23:0] d);
        @(negedge i_clk);
        o_evt_wdata = d[15:0];
        o_pwr_level = d;
        case (k)
            0: o_evt_rd = 1'b1;
            1: o_evt_wr = 1'b1;
            2: o_pwr_wr = 1'b1;
            default: o_pwr_rd = 1'b1;
        endcase
        @(negedge i_clk);
        {o_evt_rd, o_evt_wr, o_pwr_wr, o_pwr_rd} = 4'h0;
        o_evt_wdata = ~d[15:0];
        o_pwr_level = ~d;
    endtask : strobe
endmodule : oser_host_model

`default_nettype wire

// >>> test_operation_status_event_reg.sv
// Purpose: Self-checking bench for the operation status event block
// Assumes: Inputs settle within six cycles, interlock path included
// Notes: Expected words are queued by the driver and popped on valid
`timescale 1ns/100ps
`default_nettype none

module test_operation_status_event_reg
    import oser_pkg::*;
;
    logic i_clk, i_nrst, ilk, evt_rd, evt_wr, pwr_wr, pwr_rd, evt_v, pwr_v;
    oser_state_t st;
    oser_loop_t lp;
    logic [15:0] flt, en, evt_wd, cond, evt_d, exp_evt, g_old, g_mid;
    logic [23:0] pwr_lv, stored, v;
    logic [16:0] pwr_b;
    logic [19:0] pwr_bcd;
    logic [36:0] evt_q[$], pwr_q[$], pe;
    int errors, comparisons, cycles, e;

    oser_event_reg oser_event_reg_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_state(st),
        .i_loop(lp), .i_interlock(ilk), .i_fault(flt), .i_oper_enable(en),
        .i_evt_rd(evt_rd), .i_evt_wr(evt_wr), .i_evt_wdata(evt_wd), .i_pwr_wr(pwr_wr),
        .i_pwr_level(pwr_lv), .i_pwr_rd(pwr_rd), .o_oper_cond(cond), .o_evt_data(evt_d),
        .o_evt_valid(evt_v), .o_pwr_bin(pwr_b), .o_pwr_bcd(pwr_bcd), .o_pwr_valid(pwr_v));

    oser_host_model oser_host_model_inst (.i_clk(i_clk), .o_evt_rd(evt_rd),
        .o_evt_wr(evt_wr), .o_evt_wdata(evt_wd), .o_pwr_wr(pwr_wr),
        .o_pwr_level(pwr_lv), .o_pwr_rd(pwr_rd));

    // Clock and cycle ceiling
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    // Compare and count
    task automatic chk(input string n, input logic [36:0] seen, input logic [36:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // Condition word from the supply state
    function automatic logic [15:0] cond_of();
        return {st[11:6], ilk, st[5], st[4:0], flt == 16'h0000,
            lp == OSER_LOOP_CURR, lp == OSER_LOOP_VOLT};
    endfunction : cond_of

    // Decimal digits of a readback value
    function automatic logic [19:0] to_bcd(input int x);
        logic [19:0] r;
        for (int i = 0; i < 5; i++)
        begin
            r[4*i +: 4] = 4'(x % 10);
            x = x / 10;
        end
        return r;
    endfunction : to_bcd

    // Event and power queries with their expected answers noted first
    task automatic q_evt();
        evt_q.push_back({21'h00_0000, exp_evt});
        exp_evt = 16'h0000;
        oser_host_model_inst.strobe(0, 24'h00_0000);
    endtask : q_evt
    task automatic q_pwr();
        e = (int'(stored) + 8) / 16;
        if (e > 99999)
            e = 99999;
        pwr_q.push_back({to_bcd(e), 17'(e)});
        oser_host_model_inst.strobe(3, 24'h00_0000);
    endtask : q_pwr

    // Results checked as their valid pulses appear
    always @(negedge i_clk)
    begin
        if (evt_v === 1'b1)
            chk("event word", {21'h00_0000, evt_d}, evt_q.pop_front());
        if (pwr_v === 1'b1)
        begin
            pe = pwr_q.pop_front();
            chk("power bin", {20'h0_0000, pwr_b}, {20'h0_0000, pe[16:0]});
            chk("power digits", {17'h0_0000, pwr_bcd}, {17'h0_0000, pe[36:17]});
        end
    end

    // Main sequence
    initial
    begin
        void'($urandom(54966));
        {i_nrst, ilk, st, flt, en, exp_evt, stored} = '0;
        lp = OSER_LOOP_NONE;
        repeat (6) @(negedge i_clk);
        i_nrst = 1'b1;
        q_evt();
        q_pwr();
        $display("test reset done");
        for (int it = 0; it < 60; it++)
        begin
            g_old = cond_of() & en;
            @(negedge i_clk);
            st = oser_state_t'($urandom);
            lp = oser_loop_t'($urandom % 3);
            flt = ($urandom % 2) ? 16'($urandom) : 16'h0000;
            en = ($urandom % 2) ? 16'hFFFF : 16'($urandom);
            g_mid = cond_of() & en;  // Interlock bit lags the new enable by two cycles
            ilk = 1'($urandom);
            exp_evt = exp_evt | (g_mid & ~g_old) | (cond_of() & en & ~g_mid);
            repeat (6) @(negedge i_clk);
            chk("condition word", {21'h00_0000, cond}, {21'h00_0000, cond_of()});
            if (it % 2 == 1)
                oser_host_model_inst.strobe(1, 24'($urandom));
            if (it % 3 != 0)
                q_evt();
            if (it % 4 == 0)
                q_evt();
        end
        $display("test events done");
        for (int k = 0; k < 12; k++)
        begin
            case (k)
                0: v = 24'h00_0007;
                1: v = 24'h00_0008;
                2: v = 24'h00_1388;
                3: v = PWR_MAX_Q;
                4: v = PWR_MAX_Q + 24'h00_0001;
                5: v = 24'hFF_FFFF;
                default: v = 24'($urandom % 24'h02_0000);
            endcase
            oser_host_model_inst.strobe(2, v);
            stored = (v > PWR_MAX_Q) ? PWR_MAX_Q : v;
            q_pwr();
            q_pwr();
        end
        $display("test power done");
        repeat (4) @(negedge i_clk);
        chk("pending answers", 37'(evt_q.size() + pwr_q.size()), 37'h0_0000_0000);
        finish_test();
    end
endmodule : test_operation_status_event_reg

`default_nettype wire
